//--- step_trigger_ctrl.sv
// output step trigger controller with axi4-lite register access
//
// Contract
// - step mode trigger loads triggered level
// - fixed mode accepts triggers, setpoint kept
// - immediate trigger works for any source
// - bus source takes device trigger command
// - channel source uses that channel's trigger-out
// - every trigger system idle after reset
// - initiate moves addressed systems to initiated
// - accepted trigger returns system to idle
// - pin or channel source waits forever
// - abort returns channel to idle immediately
// - trigger-out pulse on each step when enabled
// - trigger-out feeds channels and output pins
`timescale 1ns/1ps
`default_nettype none
module step_trigger_ctrl
  import trig_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // register bus
  input  wire axil_req_s              axi_req,
  output axil_rsp_s                   axi_rsp,
  // digital port pins
  input  wire logic [NPIN-1:0]        port_in,
  output logic      [NPIN-1:0]        port_out,
  output logic      [NPIN-1:0]        port_oe,
  // channel outputs
  output logic      [NCH-1:0][LW-1:0] volt_setpoint,
  output logic      [NCH-1:0][LW-1:0] curr_setpoint,
  output logic      [NCH-1:0]         chan_initiated,
  output logic      [NCH-1:0]         trig_out_evt
);

  // bus write side
  logic          aw_held_r;
  logic [AW-1:0] awaddr_r;
  logic          w_held_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;
  // bus read side
  logic          rvalid_r;
  logic [31:0]   rdata_r;
  logic [1:0]    rresp_r;
  // configuration and pins
  logic [15:0]   pincfg_r;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] port_out_r;
  logic [NPIN-1:0] port_oe_r;

  // per-channel state
  chan_cfg_s     cfg_r    [NCH];
  logic [LW-1:0] vimm_r   [NCH];
  logic [LW-1:0] cimm_r   [NCH];
  logic [LW-1:0] vtrig_r  [NCH];
  logic [LW-1:0] ctrig_r  [NCH];
  logic [NCH-1:0] armed;
  logic [NCH-1:0] take;
  logic [NCH-1:0] evt_out;
  logic [31:0]   chan_rd  [NCH];
  logic [NCH-1:0] chan_rd_ok;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // write handshake: address and data are taken in either order
  wire aw_take  = axi_req.awvalid && !aw_held_r;
  wire w_take   = axi_req.wvalid && !w_held_r;
  wire wr_fire  = aw_held_r && w_held_r && !bvalid_r;
  wire ar_take  = axi_req.arvalid && !rvalid_r;

  // write decode
  wire [2:0] w_slot   = awaddr_r[7:5];
  wire [2:0] w_reg    = awaddr_r[4:2];
  wire       w_cmd    = wr_fire && awaddr_r[7:2] == CMD_OFS[7:2];
  wire       w_stat   = awaddr_r[7:2] == STAT_OFS[7:2];
  wire       w_pincfg = wr_fire && awaddr_r[7:2] == PINCFG_OFS[7:2];
  wire       w_chan   = w_slot >= CH_SLOT_BASE
                        && w_slot < CH_SLOT_BASE + 3'(NCH) && w_reg <= CH_CTRIG_IDX;
  wire       w_ok     = w_chan || w_stat || awaddr_r[7:2] == CMD_OFS[7:2]
                        || awaddr_r[7:2] == PINCFG_OFS[7:2];
  wire [1:0] w_ch     = 2'(w_slot - CH_SLOT_BASE);
  wire [31:0] cmd_bits = merge(32'h0000_0000, wdata_r, wstrb_r);

  // command pulses, one cycle each
  wire [NCH-1:0] init_p  = w_cmd ? cmd_bits[CMD_INIT_LSB +: NCH]  : '0;
  wire [NCH-1:0] abort_p = w_cmd ? cmd_bits[CMD_ABORT_LSB +: NCH] : '0;
  wire [NCH-1:0] imm_p   = w_cmd ? cmd_bits[CMD_IMM_LSB +: NCH]   : '0;
  wire           bus_trg = w_cmd && cmd_bits[CMD_BUS_BIT];

  // pin roles: an output role wins over an input role on the same pin
  wire [NPIN-1:0] pin_out_en = pincfg_r[PIN_OUT_LSB +: NPIN];
  wire [NPIN-1:0] pin_in_en  = pincfg_r[PIN_IN_LSB +: NPIN] & ~pin_out_en;
  // s3 only delays s2, so the edge is taken from synchronised levels
  wire [NPIN-1:0] pin_rise   = pin_s2_r & ~pin_s3_r & pin_in_en;

  // read decode
  wire [2:0] r_slot = axi_req.araddr[7:5];
  wire [2:0] r_reg  = axi_req.araddr[4:2];
  wire [1:0] r_ch   = 2'(r_slot - CH_SLOT_BASE);
  wire       r_chan = r_slot >= CH_SLOT_BASE && r_slot < CH_SLOT_BASE + 3'(NCH);
  wire       r_cmd  = axi_req.araddr[7:2] == CMD_OFS[7:2];
  wire       r_stat = axi_req.araddr[7:2] == STAT_OFS[7:2];
  wire       r_pin  = axi_req.araddr[7:2] == PINCFG_OFS[7:2];
  wire [31:0] stat_word = {20'h00000, pin_s2_r, 4'h0, armed};
  wire       r_ok   = r_cmd || r_stat || r_pin || (r_chan && chan_rd_ok[r_ch]);
  wire [31:0] rd_word = r_stat ? stat_word
                      : r_pin ? {16'h0000, pincfg_r}
                      : (r_chan && chan_rd_ok[r_ch]) ? chan_rd[r_ch]
                      : 32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= axi_req.awaddr;
      end
      if (w_take)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= axi_req.wdata;
        wstrb_r  <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= w_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid_r && axi_req.bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= r_ok ? RESP_OKAY : RESP_DECERR;
    end
    else if (rvalid_r && axi_req.rready)
      rvalid_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pincfg_r <= PINCFG_RST;
    else if (w_pincfg)
      pincfg_r <= 16'(merge({16'h0000, pincfg_r}, wdata_r, wstrb_r));
  end

  // pin synchronisers and trigger-out drive
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_s3_r   <= '0;
      port_out_r <= '0;
      port_oe_r  <= '0;
    end
    else
    begin
      pin_s1_r  <= port_in;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      port_oe_r <= pin_out_en;
      for (int p = 0; p < NPIN; p++)
        port_out_r[p] <= pin_out_en[p]
                         && evt_out[pincfg_r[PIN_OSRC_LSB + 2*p +: 2]];
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      wire       sel    = wr_fire && w_chan && w_ch == 2'(c);
      wire [31:0] cfg_w = {22'h000000, cfg_r[c].idx, 2'b00, cfg_r[c].src, 1'b0,
                           cfg_r[c].step_event_output_enable, cfg_r[c].cstep, cfg_r[c].vstep};
      wire [31:0] cfg_m = merge(cfg_w, wdata_r, wstrb_r);
      wire [1:0] idx    = cfg_r[c].idx;
      wire       src_hit = (cfg_r[c].src == SRC_BUS && bus_trg)
                         || (cfg_r[c].src == SRC_PIN && pin_rise[idx])
                         || (cfg_r[c].src == SRC_CHAN && evt_out[idx]);
      wire       trig   = src_hit || imm_p[c];
      wire       vload  = take[c] && cfg_r[c].vstep;
      wire       cload  = take[c] && cfg_r[c].cstep;

      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          cfg_r[c]   <= CFG_RST;
          vimm_r[c]  <= LEVEL_RST;
          cimm_r[c]  <= LEVEL_RST;
          vtrig_r[c] <= LEVEL_RST;
          ctrig_r[c] <= LEVEL_RST;
        end
        else
        begin
          if (sel && w_reg == CH_MODE_IDX)
          begin
            cfg_r[c].vstep   <= cfg_m[MODE_VSTEP_BIT];
            cfg_r[c].cstep   <= cfg_m[MODE_CSTEP_BIT];
            cfg_r[c].step_event_output_enable <= cfg_m[MODE_EVT_OUT_BIT];
            cfg_r[c].src     <= src_e'(cfg_m[MODE_SRC_LSB +: 2]);
            cfg_r[c].idx     <= cfg_m[MODE_IDX_LSB +: 2];
          end
          if (sel && w_reg == CH_VTRIG_IDX)
            vtrig_r[c] <= LW'(merge({16'h0000, vtrig_r[c]}, wdata_r, wstrb_r));
          if (sel && w_reg == CH_CTRIG_IDX)
            ctrig_r[c] <= LW'(merge({16'h0000, ctrig_r[c]}, wdata_r, wstrb_r));
          // a step outranks a software write landing in the same cycle
          if (vload)
            vimm_r[c] <= vtrig_r[c];
          else if (sel && w_reg == CH_VIMM_IDX)
            vimm_r[c] <= LW'(merge({16'h0000, vimm_r[c]}, wdata_r, wstrb_r));
          if (cload)
            cimm_r[c] <= ctrig_r[c];
          else if (sel && w_reg == CH_CIMM_IDX)
            cimm_r[c] <= LW'(merge({16'h0000, cimm_r[c]}, wdata_r, wstrb_r));
        end
      end

      chan_step_fsm u_fsm (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .initiate     (init_p[c]),
        .abort        (abort_p[c]),
        .trigger      (trig),
        .step_capable (cfg_r[c].vstep || cfg_r[c].cstep),
        .evt_out_en   (cfg_r[c].step_event_output_enable),
        .armed        (armed[c]),
        .take_r       (take[c]),
        .evt_out_r    (evt_out[c])
      );

      assign chan_rd_ok[c] = r_reg <= CH_CTRIG_IDX;
      assign chan_rd[c] = r_reg == CH_MODE_IDX  ? cfg_w
                        : r_reg == CH_VIMM_IDX  ? {16'h0000, vimm_r[c]}
                        : r_reg == CH_CIMM_IDX  ? {16'h0000, cimm_r[c]}
                        : r_reg == CH_VTRIG_IDX ? {16'h0000, vtrig_r[c]}
                        : r_reg == CH_CTRIG_IDX ? {16'h0000, ctrig_r[c]}
                        : 32'h0000_0000;
      assign volt_setpoint[c] = vimm_r[c];
      assign curr_setpoint[c] = cimm_r[c];
    end
  endgenerate

  assign chan_initiated = armed;
  assign trig_out_evt   = evt_out;
  assign port_out       = port_out_r;
  assign port_oe        = port_oe_r;

  assign axi_rsp.awready = !aw_held_r;
  assign axi_rsp.wready  = !w_held_r;
  assign axi_rsp.bvalid  = bvalid_r;
  assign axi_rsp.bresp   = bresp_r;
  assign axi_rsp.arready = !rvalid_r;
  assign axi_rsp.rvalid  = rvalid_r;
  assign axi_rsp.rdata   = rdata_r;
  assign axi_rsp.rresp   = rresp_r;

endmodule
`default_nettype wire

//--- trig_ctrl_pkg.sv
// shared constants and types for the output step trigger controller
package trig_ctrl_pkg;

  localparam int NCH = 4;
  localparam int NPIN = 4;
  localparam int LW = 16;
  localparam int AW = 8;

  // register map
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] PINCFG_OFS = 8'h08;
  localparam logic [2:0] CH_SLOT_BASE = 3'h1;
  localparam logic [2:0] CH_MODE_IDX  = 3'h0;
  localparam logic [2:0] CH_VIMM_IDX  = 3'h1;
  localparam logic [2:0] CH_CIMM_IDX  = 3'h2;
  localparam logic [2:0] CH_VTRIG_IDX = 3'h3;
  localparam logic [2:0] CH_CTRIG_IDX = 3'h4;

  // command register fields
  localparam int CMD_INIT_LSB  = 0;
  localparam int CMD_ABORT_LSB = 4;
  localparam int CMD_IMM_LSB   = 8;
  localparam int CMD_BUS_BIT   = 12;

  // status register fields
  localparam int STAT_ARMED_LSB = 0;
  localparam int STAT_PIN_LSB   = 8;

  // per-channel mode register fields
  localparam int MODE_VSTEP_BIT = 0;
  localparam int MODE_CSTEP_BIT = 1;
  localparam int MODE_EVT_OUT_BIT = 2;
  localparam int MODE_SRC_LSB   = 4;
  localparam int MODE_IDX_LSB   = 8;

  // pin configuration fields
  localparam int PIN_IN_LSB   = 0;
  localparam int PIN_OUT_LSB  = 4;
  localparam int PIN_OSRC_LSB = 8;

  // reset values
  localparam logic [15:0]   PINCFG_RST = 16'h0000;
  localparam logic [LW-1:0] LEVEL_RST  = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {SRC_BUS, SRC_PIN, SRC_CHAN, SRC_NONE} src_e;

  typedef struct packed {
    logic [1:0] idx;
    src_e       src;
    logic       step_event_output_enable;
    logic       cstep;
    logic       vstep;
  } chan_cfg_s;

  localparam chan_cfg_s CFG_RST = '{idx: 2'h0, src: SRC_BUS,
                                    step_event_output_enable: 1'b0,
                                    cstep: 1'b0, vstep: 1'b0};

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage

//--- chan_step_fsm.sv
// idle / initiated sequencer of one channel's transient system
`timescale 1ns/1ps
`default_nettype none
module chan_step_fsm
  import trig_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // commands and triggers
  input  wire logic initiate,
  input  wire logic abort,
  input  wire logic trigger,
  input  wire logic step_capable,
  input  wire logic evt_out_en,
  // results
  output logic      armed,
  output logic      take_r,
  output logic      evt_out_r
);

  typedef enum logic {IDLE, ARMED} fsm_e;

  fsm_e state_r;
  fsm_e state_nxt;
  logic accept;

  // only an armed system takes a trigger; abort beats a same-cycle trigger
  assign accept = (state_r == ARMED) && trigger && !abort;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      IDLE:
      begin
        if (initiate && !abort)
          state_nxt = ARMED;
      end
      ARMED:
      begin
        // no timeout: stays here until a trigger or an abort
        if (abort)
          state_nxt = IDLE;
        else if (trigger)
          state_nxt = IDLE;
      end
      default:
        state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r <= IDLE;
      take_r  <= 1'b0;
      evt_out_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      take_r  <= accept;
      evt_out_r <= accept && step_capable && evt_out_en;
    end
  end

  assign armed = (state_r == ARMED);

endmodule
`default_nettype wire

//--- step_trigger_ctrl_asserts.sv
// port-level checks of the step trigger controller
`timescale 1ns/1ps
`default_nettype none
module step_trigger_ctrl_asserts
  import trig_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   reset,
  // register bus
  input wire axil_req_s              axi_req,
  input wire axil_rsp_s              axi_rsp,
  // pins
  input wire logic [NPIN-1:0]        port_in,
  input wire logic [NPIN-1:0]        port_out,
  input wire logic [NPIN-1:0]        port_oe,
  // channels
  input wire logic [NCH-1:0][LW-1:0] volt_setpoint,
  input wire logic [NCH-1:0][LW-1:0] curr_setpoint,
  input wire logic [NCH-1:0]         chan_initiated,
  input wire logic [NCH-1:0]         trig_out_evt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // a step lands one cycle after the wait ends, so remember a fall
  logic [NCH-1:0] init_q;
  logic           fell_q;
  always_ff @(posedge sys_clk)
  begin
    init_q <= chan_initiated;
    fell_q <= |(init_q & ~chan_initiated);
  end

  sequence commit_s;
    $rose(axi_rsp.bvalid);
  endsequence
  sequence new_arm_s;
    (chan_initiated & ~$past(chan_initiated)) != '0;
  endsequence

  idle_after_reset_a: assert property (
    $fell(reset) |-> chan_initiated == '0 && trig_out_evt == '0) else $error("not idle");
  arm_on_commit_a: assert property (
    new_arm_s |-> commit_s) else $error("armed without command");
  step_ends_wait_a: assert property (
    (trig_out_evt & ~($past(chan_initiated) & ~chan_initiated)) == '0) else $error("bad step");
  pulse_single_a: assert property (
    trig_out_evt != '0 |=> (trig_out_evt & $past(trig_out_evt)) == '0) else $error("long pulse");
  pin_follows_a: assert property (
    port_out != '0 |-> $past(trig_out_evt != '0) && (port_out & ~port_oe) == '0)
    else $error("pin pulse without event");
  setpoint_cause_a: assert property (
    !$stable(volt_setpoint) || !$stable(curr_setpoint) |-> $rose(axi_rsp.bvalid) || fell_q)
    else $error("setpoint moved without cause");
  read_answer_a: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("late read");
  write_busy_a: assert property (
    commit_s |-> $past(!axi_rsp.awready && !axi_rsp.wready)) else $error("commit without both held");
endmodule
bind step_trigger_ctrl step_trigger_ctrl_asserts u_step_trigger_ctrl_asserts (
  .sys_clk, .reset, .axi_req, .axi_rsp, .port_in, .port_out, .port_oe,
  .volt_setpoint, .curr_setpoint, .chan_initiated, .trig_out_evt);
`default_nettype wire

//--- host_model.sv
// register bus master and pin driver standing in for the host
`timescale 1ns/1ps
`default_nettype none
module host_model
  import trig_ctrl_pkg::*;
(
  // clock
  input  wire logic           sys_clk,
  // register bus
  output var axil_req_s       axi_req,
  input  wire axil_rsp_s      axi_rsp,
  // pins and hang flag
  output var logic [NPIN-1:0] port_in,
  output var logic            hung
);
  initial
  begin
    axi_req = '0;
    port_in = '0;
    hung = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid && n < 100);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    hung <= (n >= 100);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid && n < 100);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
    hung <= (n >= 100);
  endtask

  // held long enough to pass the input synchroniser, idles low
  task automatic pulse(input int p);
    @(posedge sys_clk);
    port_in[p] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    port_in[p] <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- step_trigger_ctrl_tb.sv
// self-checking bench of the step trigger controller
`timescale 1ns/1ps
`default_nettype none
module step_trigger_ctrl_tb
  import trig_ctrl_pkg::*;
;
  logic                   sys_clk = 1'b0;
  logic                   reset = 1'b1;
  axil_req_s              axi_req;
  axil_rsp_s              axi_rsp;
  logic [NPIN-1:0]        port_in, port_out, port_oe;
  logic [NCH-1:0][LW-1:0] volt_setpoint, curr_setpoint;
  logic [NCH-1:0]         chan_initiated, trig_out_evt;
  logic                   hung;
  logic [31:0]            seed = 32'h7ed232f9, rdat;
  logic [1:0]             resp;
  int                     fail_count = 0, tests_run = 0, pin_n = 0;
  int                     evt_n [NCH] = '{default: 0};
  int                     en [NCH] = '{default: 0};
  int unsigned            vs [NCH] = '{default: 0}, cs [NCH] = '{default: 0};
  int unsigned            vt [NCH], ct [NCH];
  bit                     vst [NCH], cst [NCH], ini [NCH] = '{default: 0};

  always #20 sys_clk = ~sys_clk;

  step_trigger_ctrl u_step_trigger_ctrl (.sys_clk, .reset, .axi_req, .axi_rsp, .port_in,
    .port_out, .port_oe, .volt_setpoint, .curr_setpoint, .chan_initiated, .trig_out_evt);
  host_model u_host_model (.sys_clk, .axi_req, .axi_rsp, .port_in, .hung);

  always @(posedge sys_clk)
  begin
    for (int i = 0; i < NCH; i++)
      evt_n[i] += (trig_out_evt[i] === 1'b1);
    pin_n += (port_out[0] === 1'b1);
  end

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge hung)
  begin
    fail_count++;
    print_verdict();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    u_host_model.wr(a, d, resp);
    chk(resp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    u_host_model.rd(a, rdat, resp);
    chk(rdat, ed);
    chk(resp, er);
  endtask

  // mode with source, then levels: the order a host must keep
  task automatic setup(input int ch, input src_e src, input logic [1:0] idx);
    logic [7:0] b;
    b = 8'((ch + 1) * 32);
    vst[ch] = (ch != 3);
    cst[ch] = xs() & 32'h1;
    vs[ch] = xs() & 32'hffff;
    cs[ch] = xs() & 32'hffff;
    vt[ch] = xs() & 32'hffff;
    ct[ch] = xs() & 32'hffff;
    wr(b, {22'h0, idx, 2'b00, src, 2'b01, cst[ch], vst[ch]}, RESP_OKAY);
    wr(b + 8'h04, vs[ch], RESP_OKAY);
    wr(b + 8'h08, cs[ch], RESP_OKAY);
    wr(b + 8'h0c, vt[ch], RESP_OKAY);
    wr(b + 8'h10, ct[ch], RESP_OKAY);
  endtask

  task automatic fire(input int ch);
    ini[ch] = 0;
    if (vst[ch])
      vs[ch] = vt[ch];
    if (cst[ch])
      cs[ch] = ct[ch];
    if (vst[ch] || cst[ch])
      en[ch]++;
  endtask

  task automatic cmp_ch(input int ch);
    repeat (6) @(posedge sys_clk);
    chk(volt_setpoint[ch], vs[ch]);
    chk(curr_setpoint[ch], cs[ch]);
    chk(chan_initiated[ch], ini[ch]);
    chk(evt_n[ch], en[ch]);
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(chan_initiated, 32'h0);
    rd(STAT_OFS, 32'h0, RESP_OKAY);
    rd(PINCFG_OFS, 32'h0, RESP_OKAY);
    rd(8'ha0, 32'h0, RESP_DECERR);
    wr(8'ha0, 32'h1234, RESP_DECERR);
    // every channel: idle trigger, initiate, immediate trigger
    for (int ch = 0; ch < NCH; ch++)
    begin
      setup(ch, SRC_NONE, 2'h0);
      wr(CMD_OFS, 32'h100 << ch, RESP_OKAY);
      cmp_ch(ch);
      wr(CMD_OFS, 32'h1 << ch, RESP_OKAY);
      ini[ch] = 1;
      cmp_ch(ch);
      wr(CMD_OFS, 32'h100 << ch, RESP_OKAY);
      fire(ch);
      cmp_ch(ch);
    end
    setup(0, SRC_BUS, 2'h0);
    wr(CMD_OFS, 32'h1, RESP_OKAY);
    ini[0] = 1;
    wr(CMD_OFS, 32'h1 << CMD_BUS_BIT, RESP_OKAY);
    fire(0);
    cmp_ch(0);
    // channel 1 listens to channel 0, pin 0 repeats channel 0
    setup(0, SRC_NONE, 2'h0);
    setup(1, SRC_CHAN, 2'h0);
    wr(PINCFG_OFS, 32'h10, RESP_OKAY);
    wr(CMD_OFS, 32'h3, RESP_OKAY);
    ini[0] = 1;
    ini[1] = 1;
    wr(CMD_OFS, 32'h100, RESP_OKAY);
    fire(0);
    fire(1);
    cmp_ch(0);
    cmp_ch(1);
    chk(pin_n, 32'h1);
    chk(port_oe, 32'h1);
    wr(PINCFG_OFS, 32'h12, RESP_OKAY);
    setup(2, SRC_PIN, 2'h1);
    wr(CMD_OFS, 32'h4, RESP_OKAY);
    ini[2] = 1;
    repeat (40) @(posedge sys_clk);
    cmp_ch(2);
    u_host_model.pulse(1);
    fire(2);
    cmp_ch(2);
    wr(CMD_OFS, 32'h8, RESP_OKAY);
    ini[3] = 1;
    cmp_ch(3);
    wr(CMD_OFS, 32'h80, RESP_OKAY);
    ini[3] = 0;
    cmp_ch(3);
    wr(CMD_OFS, 32'h800, RESP_OKAY);
    cmp_ch(3);
    chk(pin_n, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
